//--- src/bsp_cfg.svh
// Register map, field positions and reset values of the serial port block
`ifndef BSP_CFG_SVH
`define BSP_CFG_SVH
`define BSP_CTL_ADR  4'h0
`define BSP_STS_ADR  4'h4
`define BSP_RXD_ADR  4'h8
`define BSP_TXD_ADR  4'hc
`define BSP_CTL_RST  32'h0070_0070
`define BSP_RX_RSTN  0
`define BSP_RX_IGN   1
`define BSP_RX_DLY   3:2
`define BSP_RX_LEN   8:4
`define BSP_RX_SEL   10:9
`define BSP_TX_RSTN  16
`define BSP_TX_IGN   17
`define BSP_TX_DLY   19:18
`define BSP_TX_LEN   24:20
`define BSP_TX_SEL   26:25
`define BSP_ST_RX_READY_FLAG  0
`define BSP_ST_ROVR  1
`define BSP_ST_RERR  2
`define BSP_ST_TRDY  8
`define BSP_ST_TUNF  9
`define BSP_ST_TERR  10
`define BSP_IRQ_RDY  2'h0
`define BSP_IRQ_ERR  2'h3
`define BSP_RESP_OK  2'h0
`define BSP_RESP_ERR 2'h2
`define BSP_LNK_RCK  0
`define BSP_LNK_RFS  1
`define BSP_LNK_RDI  2
`define BSP_LNK_TCK  3
`define BSP_LNK_TFS  4
`endif

//--- src/bsp_pkg.sv
// Shared types of the serial port block
package bsp_pkg;
  typedef logic [31:0] bsp_word_t;
  typedef logic [5:0]  bsp_cnt_t;
endpackage

//--- src/bsp_sync.sv
// Two-flop synchroniser with edge detection for the link pins
`timescale 1ns/1ps
module bsp_sync #(
  parameter int W = 5
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Asynchronous inputs
  input  wire logic [W-1:0] d,
  // Synchronised level and edges
  output logic      [W-1:0] q,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end
    else
    begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  assign q    = s2_ff;
  assign rise = s2_ff & ~s3_ff;
  assign fall = ~s2_ff & s3_ff;
endmodule

//--- src/bsp_top.sv
// Buffered serial port core with frame sync error handling and AXI4-Lite registers
// What this block does
// - Per-direction ignore bit disregards unexpected syncs
// - Sync earlier than data delay is unexpected
// - Receive abort: discard, flag error, restart element
// - Receive ignore keeps current element going
// - Transmit abort: flag error, resend same element
// - Transmit ignore keeps shifting current element
// - Ignore packs short frames into long elements
// - Overrun when data, buffer, shifter all full
// - Shifter to buffer only after buffer copied
// - Overrun needs at least three received elements
// - Data read or reset clears overrun flag
// - After overrun clear, wait for new sync
// - First sync or gap sync is normal
// - Receive sync error sticky, software writable
// - Select 11b routes receive error to irq
// - Second data write replaces untransmitted value
// - Same handling for any sync source
// - Transmit error sticky, select 11b drives irq
// - Underflow resends old data every frame
// - Ready set on copy, cleared on read (receive) or write (transmit)
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "bsp_cfg.svh"
module bsp_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Serial link
  input  wire logic        rx_bit_clock,
  input  wire logic        rx_frame_sync,
  input  wire logic        rx_serial_in,
  input  wire logic        tx_bit_clock,
  input  wire logic        tx_frame_sync,
  output logic             tx_serial_out,
  output logic             tx_serial_oe,
  // Processor and DMA events
  output logic             rx_irq,
  output logic             tx_irq,
  output logic             tx_dma_event
);
  logic [4:0]         lk_q;
  logic [4:0]         lk_rise;
  logic [4:0]         lk_fall;
  bsp_pkg::bsp_word_t ctl_ff;
  logic               aw_ff;
  logic               w_ff;
  logic [3:0]         awa_ff;
  bsp_pkg::bsp_word_t wd_ff;
  logic [3:0]         ws_ff;
  logic               wr_go;
  logic               ar_hs;
  logic               st_wr;
  logic               tx_wr;
  logic               rx_rd;
  bsp_pkg::bsp_word_t rd_mux;
  // Receive side
  logic               rx_rstn;
  logic               rx_ign;
  logic [1:0]         rx_dly;
  bsp_pkg::bsp_cnt_t  rx_len;
  logic               rx_edge;
  logic               rx_fs_evt;
  logic               rx_unexp;
  logic               rx_abort;
  logic               rx_start;
  logic               rx_done;
  logic               rx_cp;
  logic               rx_stop;
  logic               ovr_set;
  logic               rx_fs_last_ff;
  logic               rx_pend_ff;
  logic [1:0]         rx_dcnt_ff;
  bsp_pkg::bsp_cnt_t  rx_rem_ff;
  bsp_pkg::bsp_word_t rx_shift_reg_ff;
  logic               nxt_rx_pend;
  logic [1:0]         nxt_rx_dcnt;
  bsp_pkg::bsp_cnt_t  nxt_rx_rem;
  bsp_pkg::bsp_word_t nxt_rx_shift;
  bsp_pkg::bsp_word_t rx_buffer_reg_ff;
  bsp_pkg::bsp_word_t rx_data_reg_ff;
  logic               rx_buf_full_ff;
  logic               rx_ready_flag_ff;
  logic               rx_overrun_flag_ff;
  logic               rx_sync_error_ff;
  // Transmit side
  logic               tx_rstn;
  logic               tx_ign;
  logic [1:0]         tx_dly;
  bsp_pkg::bsp_cnt_t  tx_len;
  logic               tx_edge;
  logic               tx_fs_evt;
  logic               tx_unexp;
  logic               tx_abort;
  logic               tx_start;
  logic               tx_done;
  logic               tx_copy;
  bsp_pkg::bsp_word_t tx_src;
  logic               tx_fs_last_ff;
  logic               tx_pend_ff;
  logic [1:0]         tx_dcnt_ff;
  bsp_pkg::bsp_cnt_t  tx_rem_ff;
  bsp_pkg::bsp_word_t tx_shift_reg_ff;
  logic               tx_out_ff;
  logic               tx_oe_ff;
  logic               nxt_tx_pend;
  logic [1:0]         nxt_tx_dcnt;
  bsp_pkg::bsp_cnt_t  nxt_tx_rem;
  bsp_pkg::bsp_word_t nxt_tx_shift;
  logic               nxt_tx_out;
  logic               nxt_tx_oe;
  bsp_pkg::bsp_word_t tx_data_reg_ff;
  bsp_pkg::bsp_word_t tx_elem_ff;
  logic               tx_ready_flag_ff;
  logic               tx_underflow_n_ff;
  logic               tx_sync_error_ff;
  logic               tx_evt_ff;

  bsp_sync #(.W(5)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({tx_frame_sync, tx_bit_clock, rx_serial_in, rx_frame_sync, rx_bit_clock}),
    .q       (lk_q),
    .rise    (lk_rise),
    .fall    (lk_fall)
  );

  // Bus slave
  assign awready = ~aw_ff & ~bvalid;
  assign wready  = ~w_ff & ~bvalid;
  assign arready = ~rvalid;
  assign wr_go   = aw_ff & w_ff;
  assign ar_hs   = arvalid & arready;
  assign st_wr   = wr_go & (awa_ff == `BSP_STS_ADR);
  assign tx_wr   = wr_go & (awa_ff == `BSP_TXD_ADR);
  assign rx_rd   = ar_hs & (araddr == `BSP_RXD_ADR);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ff  <= 1'b0;
      w_ff   <= 1'b0;
      awa_ff <= 4'h0;
      wd_ff  <= 32'h0;
      ws_ff  <= 4'h0;
      bvalid <= 1'b0;
      bresp  <= `BSP_RESP_OK;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_ff  <= 1'b1;
        awa_ff <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_ff  <= 1'b1;
        wd_ff <= wdata;
        ws_ff <= wstrb;
      end
      if (wr_go)
      begin
        aw_ff  <= 1'b0;
        w_ff   <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= (awa_ff == `BSP_RXD_ADR || awa_ff[1:0] != 2'h0) ? `BSP_RESP_ERR : `BSP_RESP_OK;
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctl_ff <= `BSP_CTL_RST;
    else if (wr_go && awa_ff == `BSP_CTL_ADR)
    begin
      for (int i = 0; i < 4; i++)
        if (ws_ff[i])
          ctl_ff[i*8 +: 8] <= wd_ff[i*8 +: 8];
    end
  end

  always_comb
  begin
    rd_mux = 32'h0;
    if (araddr == `BSP_CTL_ADR)
      rd_mux = ctl_ff;
    else if (araddr == `BSP_STS_ADR)
    begin
      rd_mux[`BSP_ST_RX_READY_FLAG] = rx_ready_flag_ff;
      rd_mux[`BSP_ST_ROVR] = rx_overrun_flag_ff;
      rd_mux[`BSP_ST_RERR] = rx_sync_error_ff;
      rd_mux[`BSP_ST_TRDY] = tx_ready_flag_ff;
      rd_mux[`BSP_ST_TUNF] = tx_underflow_n_ff;
      rd_mux[`BSP_ST_TERR] = tx_sync_error_ff;
    end
    else if (araddr == `BSP_RXD_ADR)
      rd_mux = rx_data_reg_ff;
    else if (araddr == `BSP_TXD_ADR)
      rd_mux = tx_data_reg_ff;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= `BSP_RESP_OK;
    end
    else if (ar_hs)
    begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= (araddr[1:0] != 2'h0) ? `BSP_RESP_ERR : `BSP_RESP_OK;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // Receiver: bits and syncs taken on falling bit clock edges
  assign rx_rstn   = ctl_ff[`BSP_RX_RSTN];
  assign rx_ign    = ctl_ff[`BSP_RX_IGN];
  assign rx_dly    = ctl_ff[`BSP_RX_DLY];
  assign rx_len    = {1'b0, ctl_ff[`BSP_RX_LEN]} + 6'h01;
  assign rx_edge   = lk_fall[`BSP_LNK_RCK];
  assign rx_fs_evt = lk_q[`BSP_LNK_RFS] & ~rx_fs_last_ff;
  assign rx_unexp  = (rx_rem_ff > {4'h0, rx_dly}) | rx_pend_ff;
  assign rx_abort  = rx_edge & rx_fs_evt & rx_unexp & ~rx_ign;
  assign rx_start  = rx_edge & rx_fs_evt & (~rx_unexp | ~rx_ign);

  always_comb
  begin
    nxt_rx_pend  = rx_pend_ff;
    nxt_rx_dcnt  = rx_dcnt_ff;
    nxt_rx_rem   = rx_rem_ff;
    nxt_rx_shift = rx_shift_reg_ff;
    rx_done      = 1'b0;
    if (rx_edge)
    begin
      if (rx_start)
      begin
        nxt_rx_pend = 1'b1;
        nxt_rx_dcnt = rx_dly;
        if (rx_abort)
          nxt_rx_rem = 6'h00;
      end
      if (nxt_rx_pend && nxt_rx_dcnt == 2'h0)
      begin
        nxt_rx_pend  = 1'b0;
        nxt_rx_rem   = rx_len;
        nxt_rx_shift = 32'h0;
      end
      else if (nxt_rx_pend)
        nxt_rx_dcnt = nxt_rx_dcnt - 2'h1;
      if (nxt_rx_rem != 6'h00)
      begin
        nxt_rx_shift = {nxt_rx_shift[30:0], lk_q[`BSP_LNK_RDI]};
        nxt_rx_rem   = nxt_rx_rem - 6'h01;
        rx_done      = (nxt_rx_rem == 6'h00);
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rx_rstn || rx_stop)
    begin
      rx_fs_last_ff   <= 1'b0;
      rx_pend_ff      <= 1'b0;
      rx_dcnt_ff      <= 2'h0;
      rx_rem_ff       <= 6'h00;
      rx_shift_reg_ff <= 32'h0;
    end
    else
    begin
      if (rx_edge)
        rx_fs_last_ff <= lk_q[`BSP_LNK_RFS];
      rx_pend_ff      <= nxt_rx_pend;
      rx_dcnt_ff      <= nxt_rx_dcnt;
      rx_rem_ff       <= nxt_rx_rem;
      rx_shift_reg_ff <= nxt_rx_shift;
    end
  end

  // Receive buffering: shifter, buffer, data register
  assign rx_cp   = rx_buf_full_ff & ~rx_ready_flag_ff;
  assign ovr_set = rx_done & rx_buf_full_ff & ~rx_cp;
  assign rx_stop = rx_rd & rx_overrun_flag_ff & ~ovr_set;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rx_rstn)
    begin
      rx_buffer_reg_ff   <= 32'h0;
      rx_data_reg_ff     <= 32'h0;
      rx_buf_full_ff     <= 1'b0;
      rx_ready_flag_ff   <= 1'b0;
      rx_overrun_flag_ff <= 1'b0;
    end
    else
    begin
      if (rx_cp)
        rx_data_reg_ff <= rx_buffer_reg_ff;
      if (rx_done && !ovr_set)
      begin
        rx_buffer_reg_ff <= nxt_rx_shift;
        rx_buf_full_ff   <= 1'b1;
      end
      else if (rx_cp)
        rx_buf_full_ff <= 1'b0;
      if (rx_cp)
        rx_ready_flag_ff <= 1'b1;
      else if (rx_rd)
        rx_ready_flag_ff <= 1'b0;
      if (ovr_set)
        rx_overrun_flag_ff <= 1'b1;
      else if (rx_rd)
        rx_overrun_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !rx_rstn)
      rx_sync_error_ff <= 1'b0;
    else if (rx_abort)
      rx_sync_error_ff <= 1'b1;
    else if (st_wr && ws_ff[0])
      rx_sync_error_ff <= wd_ff[`BSP_ST_RERR];
  end

  // Transmitter: syncs taken and bits driven on rising bit clock edges
  assign tx_rstn   = ctl_ff[`BSP_TX_RSTN];
  assign tx_ign    = ctl_ff[`BSP_TX_IGN];
  assign tx_dly    = ctl_ff[`BSP_TX_DLY];
  assign tx_len    = {1'b0, ctl_ff[`BSP_TX_LEN]} + 6'h01;
  assign tx_edge   = lk_rise[`BSP_LNK_TCK];
  assign tx_fs_evt = lk_q[`BSP_LNK_TFS] & ~tx_fs_last_ff;
  assign tx_unexp  = (tx_rem_ff > {4'h0, tx_dly}) | tx_pend_ff;
  assign tx_abort  = tx_edge & tx_fs_evt & tx_unexp & ~tx_ign;
  assign tx_start  = tx_edge & tx_fs_evt & (~tx_unexp | ~tx_ign);
  assign tx_copy   = tx_start & ~tx_abort & ~tx_ready_flag_ff;
  // Normal frames take the data register, stale or fresh; an abort resends the element
  assign tx_src    = (tx_start && !tx_abort) ? tx_data_reg_ff : tx_elem_ff;

  always_comb
  begin
    nxt_tx_pend  = tx_pend_ff;
    nxt_tx_dcnt  = tx_dcnt_ff;
    nxt_tx_rem   = tx_rem_ff;
    nxt_tx_shift = tx_shift_reg_ff;
    nxt_tx_out   = tx_out_ff;
    nxt_tx_oe    = tx_oe_ff;
    tx_done      = 1'b0;
    if (tx_edge)
    begin
      nxt_tx_oe = 1'b0;
      if (tx_start)
      begin
        nxt_tx_pend = 1'b1;
        nxt_tx_dcnt = tx_dly;
        if (tx_abort)
          nxt_tx_rem = 6'h00;
      end
      if (nxt_tx_pend && nxt_tx_dcnt == 2'h0)
      begin
        nxt_tx_pend  = 1'b0;
        nxt_tx_rem   = tx_len;
        nxt_tx_shift = tx_src << (6'h20 - tx_len);
      end
      else if (nxt_tx_pend)
        nxt_tx_dcnt = nxt_tx_dcnt - 2'h1;
      if (nxt_tx_rem != 6'h00)
      begin
        nxt_tx_out   = nxt_tx_shift[31];
        nxt_tx_oe    = 1'b1;
        nxt_tx_shift = {nxt_tx_shift[30:0], 1'b0};
        nxt_tx_rem   = nxt_tx_rem - 6'h01;
        tx_done      = (nxt_tx_rem == 6'h00);
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !tx_rstn)
    begin
      tx_fs_last_ff   <= 1'b0;
      tx_pend_ff      <= 1'b0;
      tx_dcnt_ff      <= 2'h0;
      tx_rem_ff       <= 6'h00;
      tx_shift_reg_ff <= 32'h0;
      tx_out_ff       <= 1'b0;
      tx_oe_ff        <= 1'b0;
    end
    else
    begin
      if (tx_edge)
        tx_fs_last_ff <= lk_q[`BSP_LNK_TFS];
      tx_pend_ff      <= nxt_tx_pend;
      tx_dcnt_ff      <= nxt_tx_dcnt;
      tx_rem_ff       <= nxt_tx_rem;
      tx_shift_reg_ff <= nxt_tx_shift;
      tx_out_ff       <= nxt_tx_out;
      tx_oe_ff        <= nxt_tx_oe;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tx_data_reg_ff <= 32'h0;
    else if (tx_wr)
    begin
      for (int i = 0; i < 4; i++)
        if (ws_ff[i])
          tx_data_reg_ff[i*8 +: 8] <= wd_ff[i*8 +: 8];
    end
  end

  // A write in the copy cycle wins, so the fresh value stays pending
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !tx_rstn)
    begin
      tx_elem_ff        <= 32'h0;
      tx_ready_flag_ff  <= 1'b1;
      tx_underflow_n_ff <= 1'b0;
      tx_evt_ff         <= 1'b0;
    end
    else
    begin
      tx_evt_ff <= tx_copy;
      if (tx_start && !tx_abort)
        tx_elem_ff <= tx_data_reg_ff;
      if (tx_wr)
        tx_ready_flag_ff <= 1'b0;
      else if (tx_copy)
        tx_ready_flag_ff <= 1'b1;
      if (tx_copy)
        tx_underflow_n_ff <= 1'b1;
      else if (tx_done && tx_ready_flag_ff)
        tx_underflow_n_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !tx_rstn)
      tx_sync_error_ff <= 1'b0;
    else if (tx_abort)
      tx_sync_error_ff <= 1'b1;
    else if (st_wr && ws_ff[1])
      tx_sync_error_ff <= wd_ff[`BSP_ST_TERR];
  end

  assign tx_serial_out = tx_out_ff;
  assign tx_serial_oe  = tx_oe_ff;
  assign tx_dma_event  = tx_evt_ff;
  assign rx_irq = (ctl_ff[`BSP_RX_SEL] == `BSP_IRQ_ERR) ? rx_sync_error_ff :
                  (ctl_ff[`BSP_RX_SEL] == `BSP_IRQ_RDY) & rx_ready_flag_ff;
  assign tx_irq = (ctl_ff[`BSP_TX_SEL] == `BSP_IRQ_ERR) ? tx_sync_error_ff :
                  (ctl_ff[`BSP_TX_SEL] == `BSP_IRQ_RDY) & tx_ready_flag_ff;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ovr_set_a: assert property (ovr_set && rx_rstn |=> rx_overrun_flag_ff)
    else $error("overrun not flagged");
  ovr_clr_a: assert property (rx_rd && !ovr_set && rx_rstn |=> !rx_overrun_flag_ff)
    else $error("overrun not cleared by read");
  rx_abort_a: assert property (rx_abort && rx_rstn && !rx_stop |=>
    rx_sync_error_ff && (rx_pend_ff || rx_rem_ff == rx_len - 6'h01)) else $error("receive abort wrong");
  rx_ign_a: assert property (rx_edge && rx_fs_evt && rx_ign && rx_rem_ff > {4'h0, rx_dly}
    && rx_rstn && !rx_stop |=> rx_rem_ff == $past(rx_rem_ff) - 6'h01) else $error("ignored sync disturbed rx");
  tx_abort_a: assert property (tx_abort && tx_rstn |=> tx_sync_error_ff && $stable(tx_elem_ff)
    && (tx_pend_ff || tx_rem_ff == tx_len - 6'h01)) else $error("transmit abort wrong");
  tx_ign_a: assert property (tx_edge && tx_fs_evt && tx_ign && tx_rem_ff > {4'h0, tx_dly}
    && tx_rstn |=> tx_rem_ff == $past(tx_rem_ff) - 6'h01) else $error("ignored sync disturbed tx");
  rbuf_hold_a: assert property (ovr_set && rx_rstn |=> $stable(rx_buffer_reg_ff))
    else $error("buffer overwritten");
  rdy_set_a: assert property (rx_cp && rx_rstn |=>
    rx_ready_flag_ff && rx_data_reg_ff == $past(rx_buffer_reg_ff)) else $error("copy not flagged");
  rerr_hold_a: assert property (rx_sync_error_ff && rx_rstn && !st_wr |=> rx_sync_error_ff)
    else $error("sync error dropped");
  rx_irq_a: assert property (ctl_ff[`BSP_RX_SEL] == `BSP_IRQ_ERR |-> rx_irq == rx_sync_error_ff)
    else $error("rx irq routing");
  tx_irq_a: assert property (ctl_ff[`BSP_TX_SEL] == `BSP_IRQ_ERR |-> tx_irq == tx_sync_error_ff)
    else $error("tx irq routing");
  txd_wr_a: assert property (tx_wr && ws_ff == 4'hf && tx_rstn |=>
    !tx_ready_flag_ff && tx_data_reg_ff == $past(wd_ff)) else $error("data write lost");
  tx_resend_a: assert property (tx_start && !tx_abort && tx_rstn |=>
    tx_elem_ff == $past(tx_data_reg_ff)) else $error("frame did not take data register");
endmodule

//--- test/bsp_codec_model.sv
// Codec model that drives and samples the serial link
`timescale 1ns/1ps
module bsp_codec_model (
  // Receive direction
  output logic      rx_bit_clock,
  output logic      rx_frame_sync,
  output logic      rx_serial_in,
  // Transmit direction
  output logic      tx_bit_clock,
  output logic      tx_frame_sync,
  input  wire logic tx_serial_out,
  input  wire logic tx_serial_oe
);
  initial
  begin
    rx_bit_clock = 1'b0;
    rx_frame_sync = 1'b0;
    rx_serial_in = 1'b0;
    tx_bit_clock = 1'b0;
    tx_frame_sync = 1'b0;
  end
  // Bit clocks of 160 ns run only within frames; patterns go MSB first
  task automatic rx_bits(input logic [39:0] syn, input logic [39:0] dat, input int n);
    for (int i = 0; i < n; i++)
    begin
      rx_frame_sync = syn[39-i];
      rx_serial_in = dat[39-i];
      #40 rx_bit_clock = 1'b1;
      #80 rx_bit_clock = 1'b0;
      #40;
    end
    rx_frame_sync = 1'b0;
    // Released line has no pull, so it shows the inverse
    rx_serial_in = ~rx_serial_in;
  endtask
  task automatic tx_bits(input logic [39:0] syn, input int n, output logic [39:0] got);
    got = '0;
    for (int i = 0; i < n; i++)
    begin
      tx_frame_sync = syn[39-i];
      #40 tx_bit_clock = 1'b1;
      #80 got[39-i] = tx_serial_out & tx_serial_oe;
      tx_bit_clock = 1'b0;
      #40;
    end
    tx_frame_sync = 1'b0;
  endtask
endmodule

//--- test/bsp_top_tb.sv
// Self-checking bench for the serial port core
`timescale 1ns/1ps
`include "bsp_cfg.svh"
module bsp_top_tb;
  typedef struct {
    logic [1:0]  dly;
    logic        ign;
    logic [4:0]  len;
    logic [39:0] syn;
    logic [39:0] dat;
    int          n;
    logic [31:0] exp_d;
    logic        err;
  } bsp_row_s;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, rx_irq, tx_irq, tx_dma_event;
  logic        rx_bit_clock, rx_frame_sync, rx_serial_in, tx_bit_clock, tx_frame_sync;
  logic        tx_serial_out, tx_serial_oe;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, q, c;
  logic [1:0]  bresp, rresp, rsp;
  logic [39:0] got;
  int          error_cnt, cmp_count, evt_cnt;
  bsp_row_s    rows [8];

  bsp_top uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .rx_bit_clock,
    .rx_frame_sync, .rx_serial_in, .tx_bit_clock, .tx_frame_sync, .tx_serial_out, .tx_serial_oe,
    .rx_irq, .tx_irq, .tx_dma_event);
  bsp_codec_model u_codec (.rx_bit_clock, .rx_frame_sync, .rx_serial_in, .tx_bit_clock, .tx_frame_sync,
    .tx_serial_out, .tx_serial_oe);

  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // One AXI4-Lite transfer; ready is sampled where it is settled, the mid-cycle before the edge
  task automatic axi(input logic w, input logic [3:0] a, input logic [31:0] d);
    logic pa, pw, pr, done;
    pa = w;
    pw = w;
    pr = !w;
    done = 1'b0;
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    for (int t = 0; t < 100 && !done; t++)
    begin
      @(negedge aclk);
      done = w ? bvalid : rvalid;
      rsp = w ? bresp : rresp;
      q = rdata;
      pa = pa && !awready;
      pw = pw && !wready;
      pr = pr && !arready;
      @(posedge aclk);
      awvalid <= pa;
      wvalid <= pw;
      arvalid <= pr;
      bready <= w && !done;
      rready <= !w && !done;
    end
    chk("handshake", done, 1'b1);
    @(posedge aclk);
    #1;
  endtask

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // One pulse per copy into the transmit shifter
  always @(posedge aclk)
    if (tx_dma_event === 1'b1)
      evt_cnt <= evt_cnt + 1;
  initial
  begin
    #300us;
    error_cnt++;
    report_and_stop();
  end
  initial
  begin
    {aresetn, awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'hf;
    error_cnt = 0;
    cmp_count = 0;
    evt_cnt = 0;
    rows = '{
      '{2'd0, 1'b0, 5'd7, 40'h80_0000_0000, {8'ha5, 32'h0}, 8, 32'ha5, 1'b0},
      '{2'd1, 1'b0, 5'd7, 40'h80_0000_0000, {1'b0, 8'ha5, 31'h0}, 9, 32'ha5, 1'b0},
      '{2'd2, 1'b0, 5'd7, 40'h80_0000_0000, {2'b0, 8'h3c, 30'h0}, 10, 32'h3c, 1'b0},
      '{2'd3, 1'b0, 5'd7, 40'h80_0000_0000, {3'b0, 8'hc3, 29'h0}, 11, 32'hc3, 1'b0},
      '{2'd0, 1'b0, 5'd7, 40'h90_0000_0000, {3'h7, 8'h96, 29'h0}, 11, 32'h96, 1'b1},
      '{2'd0, 1'b1, 5'd7, 40'h90_0000_0000, {3'h7, 8'h96, 29'h0}, 8, 32'hf2, 1'b0},
      '{2'd1, 1'b1, 5'd31, 40'h80_8080_8000, {1'b0, 32'hdeadbeef, 7'h0}, 33, 32'hdeadbeef, 1'b0},
      '{2'd1, 1'b0, 5'd7, 40'h80_8000_0000, {1'b0, 16'ha55a, 23'h0}, 17, 32'ha5, 1'b0}};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk("irq", {rx_irq, tx_irq}, 2'b01);
    axi(1'b0, `BSP_CTL_ADR, 32'h0);
    chk("ctl", q, 32'h0070_0070);
    axi(1'b1, `BSP_RXD_ADR, 32'h0);
    chk("resp", rsp, 2'h2);
    axi(1'b0, 4'h1, 32'h0);
    chk("resp", rsp, 2'h2);
    foreach (rows[k])
    begin
      c = {16'h0070, 5'h0, 2'h0, rows[k].len, rows[k].dly, rows[k].ign, 1'b0};
      axi(1'b1, `BSP_CTL_ADR, c);
      axi(1'b1, `BSP_CTL_ADR, c | 32'h1);
      u_codec.rx_bits(rows[k].syn, rows[k].dat, rows[k].n);
      repeat (4) @(posedge aclk);
      axi(1'b0, `BSP_STS_ADR, 32'h0);
      chk("sts", q[2:0], {rows[k].err, 2'b01});
      axi(1'b0, `BSP_RXD_ADR, 32'h0);
      chk("rxd", q, rows[k].exp_d);
    end
    // Overrun: three elements with no read in between
    axi(1'b1, `BSP_CTL_ADR, 32'h0070_0070);
    axi(1'b1, `BSP_CTL_ADR, 32'h0070_0071);
    u_codec.rx_bits(40'h80_8080_0000, {24'ha1b2c3, 16'h0}, 24);
    axi(1'b0, `BSP_STS_ADR, 32'h0);
    chk("sts", q[2:0], 3'b011);
    axi(1'b0, `BSP_RXD_ADR, 32'h0);
    chk("rxd", q, 32'ha1);
    u_codec.rx_bits(40'h0, {8'h11, 32'h0}, 8);
    axi(1'b0, `BSP_STS_ADR, 32'h0);
    chk("sts", q[2:0], 3'b001);
    axi(1'b0, `BSP_RXD_ADR, 32'h0);
    chk("rxd", q, 32'hb2);
    axi(1'b0, `BSP_STS_ADR, 32'h0);
    chk("sts", q[2:0], 3'b000);
    u_codec.rx_bits(40'h80_0000_0000, {8'h22, 32'h0}, 8);
    axi(1'b0, `BSP_RXD_ADR, 32'h0);
    chk("rxd", q, 32'h22);
    // Sticky error flags routed to the interrupts
    axi(1'b1, `BSP_CTL_ADR, 32'h0671_0671);
    axi(1'b1, `BSP_STS_ADR, 32'h0000_0404);
    chk("irq", {rx_irq, tx_irq}, 2'b11);
    axi(1'b0, `BSP_STS_ADR, 32'h0);
    chk("sts", {q[10], q[2]}, 2'b11);
    axi(1'b1, `BSP_STS_ADR, 32'h0);
    chk("irq", {rx_irq, tx_irq}, 2'b00);
    // Transmit path
    axi(1'b1, `BSP_CTL_ADR, 32'h0070_0071);
    axi(1'b1, `BSP_CTL_ADR, 32'h0071_0071);
    axi(1'b1, `BSP_TXD_ADR, 32'hc3);
    axi(1'b1, `BSP_TXD_ADR, 32'h5a);
    axi(1'b0, `BSP_STS_ADR, 32'h0);
    chk("sts", q[8], 1'b0);
    u_codec.tx_bits(40'h80_0000_0000, 8, got);
    chk("txd", got[39:32], 8'h5a);
    repeat (4) @(posedge aclk);
    axi(1'b0, `BSP_STS_ADR, 32'h0);
    chk("sts", q[9:8], 2'b01);
    u_codec.tx_bits(40'h80_0000_0000, 8, got);
    chk("txd", got[39:32], 8'h5a);
    axi(1'b1, `BSP_TXD_ADR, 32'h81);
    u_codec.tx_bits(40'h90_0000_0000, 11, got);
    chk("txd", got[39:29], {3'b100, 8'h81});
    axi(1'b0, `BSP_STS_ADR, 32'h0);
    chk("sts", q[10], 1'b1);
    axi(1'b1, `BSP_CTL_ADR, 32'h0073_0071);
    u_codec.tx_bits(40'h90_0000_0000, 8, got);
    chk("txd", got[39:32], 8'h81);
    chk("evt", evt_cnt, 32'h2);
    // Mid-run device reset clears the transmit error and restores ready
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk("irq", {rx_irq, tx_irq}, 2'b01);
    axi(1'b0, `BSP_STS_ADR, 32'h0);
    chk("sts", {q[10:8], q[2:0]}, 6'h08);
    report_and_stop();
  end
endmodule
